// >>> bench/host_bus_model.sv
// AHB-Lite master model standing in for the host CPU
`timescale 1ns/1ps
module host_bus_model
(
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // call just after a rising edge; each phase is held until hready is seen high
  task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] wd,
    output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge hclk);
    while (hready !== 1'b1)
      @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    @(posedge hclk);
    while (hready !== 1'b1)
      @(posedge hclk);
    rd = hrdata;
  endtask
endmodule

// >>> bench/testbench.sv
// self-checking bench for the alarm match unit
`timescale 1ns/1ps
`include "rtc_alarm_consts.svh"
module testbench;
  import rtc_alarm_pkg::*;
  logic hclk;
  logic hresetn;
  logic minute_tick;
  logic power_on_flag;
  time_s cur_time;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic int_n_o;
  logic int_n_oe;
  int n_errors = 0;
  int checks = 0;
  int cycles = 0;
  typedef struct packed {logic [7:0] a; logic [7:0] wd; logic [7:0] exp;} row_s;
  // address, written value, expected read back
  row_s rows [14] = '{
    '{8'h20, 8'hFF, 8'hFF}, '{8'h24, 8'hE5, 8'hE5}, '{8'h28, 8'hFF, 8'hFF},
    '{8'h2C, 8'h80, 8'h80}, '{8'h30, 8'hC5, 8'hC5}, '{8'h38, 8'hC0, 8'hC0},
    '{8'h3C, 8'h83, 8'h80}, '{8'h2C, 8'h87, 8'h87}, '{8'h30, 8'h9F, 8'h9F},
    '{8'h3C, 8'h00, 8'h00}, '{8'h38, 8'h00, 8'h00}, '{8'h00, 8'h5A, 8'h00},
    '{8'h34, 8'h11, 8'h00}, '{8'h2C, 8'h00, 8'h00}};

  host_bus_model u_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  rtc_alarm_match_unit u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cur_time(cur_time),
    .minute_tick(minute_tick), .power_on_flag(power_on_flag), .int_n_o(int_n_o),
    .int_n_oe(int_n_oe));

  initial
  begin
    hclk = 1'b0;
    forever
      #12.5 hclk = ~hclk;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] x;
    u_host.xfer(1'b1, {24'h0, a}, d, x);
  endtask

  task automatic chk8(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] g;
    u_host.xfer(1'b0, {24'h0, a}, 8'h00, g);
    checks++;
    // upper data bits are always zero and the response is always okay
    if (g !== {24'h000000, exp} || hresp !== 1'b0)
    begin
      n_errors++;
      $display("BAD %0t reg %h got %h resp %b exp %h", $time, a, g, hresp, exp);
    end
  endtask

  task automatic chk1(input logic g, input logic exp);
    checks++;
    if (g !== exp)
    begin
      n_errors++;
      $display("BAD %0t pin got %b exp %b", $time, g, exp);
    end
  endtask

  // one minute update, then status just before and well after the flag delay
  task automatic fire_check(input logic [7:0] exp);
    minute_tick <= 1'b1;
    @(posedge hclk);
    minute_tick <= 1'b0;
    repeat (`FLAG_DELAY_CYC - 12) @(posedge hclk);
    chk8(8'h3C, 8'h00);
    repeat (20) @(posedge hclk);
    chk8(8'h3C, exp);
    chk1(int_n_oe, |exp[1:0]);
    chk1(int_n_o, 1'b0);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      n_errors++;
      $display("BAD %0t run too long", $time);
      tally_and_finish();
    end
  end

  initial
  begin
    logic [7:0] dcmp;
    logic [7:0] mcmp;
    hresetn = 1'b0;
    minute_tick = 1'b0;
    power_on_flag = 1'b0;
    cur_time = '{minute: 8'h59, hour: 8'h32, weekday: 3'd3, day: 8'h08, month: 8'h01};
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 7; i++)
      chk8(rows[i].a, 8'h00);
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].wd);
      chk8(rows[i].a, rows[i].exp);
    end
    $display("test registers done");
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk8(8'h24, 8'h00);
    chk8(8'h38, 8'h00);
    $display("test reset done");
    wr(8'h20, 8'h3C);
    power_on_flag <= 1'b1;
    repeat (2) @(posedge hclk);
    chk8(8'h20, 8'h00);
    power_on_flag <= 1'b0;
    $display("test power on done");
    wr(8'h20, 8'h59);
    wr(8'h24, 8'h32);
    wr(8'h28, 8'h08);
    wr(8'h38, 8'h80);
    // compare equals the present time, but no minute update comes
    repeat (`FLAG_DELAY_CYC + 4) @(posedge hclk);
    chk8(8'h3C, 8'h00);
    fire_check(8'h02);
    wr(8'h3C, 8'h03);
    chk8(8'h3C, 8'h02);
    wr(8'h3C, 8'h00);
    chk8(8'h3C, 8'h00);
    chk1(int_n_oe, 1'b0);
    fire_check(8'h02);
    wr(8'h38, 8'h00);
    chk8(8'h3C, 8'h00);
    wr(8'h28, 8'h00);
    wr(8'h38, 8'h80);
    fire_check(8'h00);
    wr(8'h38, 8'h00);
    $display("test weekly done");
    wr(8'h2C, 8'hD9);
    wr(8'h30, 8'hF2);
    // daily, day miss, month miss, both miss, yearly, monthly, daily in month
    for (int i = 0; i < 7; i++)
    begin
      dcmp = (i == 4 || i == 5) ? 8'h88 : {i[0], 7'h47};
      mcmp = (i == 4 || i == 6) ? 8'h81 : {i[1], 7'h02};
      wr(8'h3C, 8'h80);
      wr(8'h2C, dcmp);
      wr(8'h30, mcmp);
      wr(8'h3C, 8'h00);
      wr(8'h38, 8'h40);
      fire_check((i == 0 || i >= 4) ? 8'h01 : 8'h00);
      wr(8'h38, 8'h00);
      chk8(8'h3C, 8'h00);
    end
    $display("test monthly done");
    tally_and_finish();
  end
endmodule

// >>> hw/rtc_alarm_consts.svh
// register offsets, field positions, reset values and timing counts of the alarm unit
// Overview of operation
// - an enabled alarm match sets its status flag about 61 us later
// - host writing zero clears a status flag, writing one does nothing
// - a disabled alarm always reads its status flag as zero
// - weekly minute compare is BCD at bank 0 offset 8h, bit 6 weighs 40
// - hour compare bit 5 is PM in 12-hour mode, twenty digit in 24-hour
// - in 12-hour mode the hour counter goes from AM 11 to BCD 32
// - weekday mask bits 0 to 6 each select one day-of-week value 0 to 6
// - weekly alarm never fires while all seven weekday mask bits are zero
// - monthly minute compare is BCD at bank 0 offset Bh, bit 7 spare
// - monthly hour compare at bank 0 offset Ch, bits 5 to 0, bits 7-6 spare
// - day compare at bank 1 offset Bh, bit 7 enables, bits 5-0 BCD day
// - month compare at bank 1 offset Ch, bit 7 enables, bits 4-0 BCD month
// - day and month enables pick daily, monthly, in-month daily or yearly alarm
// - spare alarm register bits are plain storage and never affect matching
// - disabled alarm compare registers serve as general storage for the host
// - when the power-on flag sets, every alarm compare bit loads zero
// - a zero day or month enable makes its other compare bits ignored
// - a flagged alarm pulls the interrupt pin low, clearing the flag releases it
// - loading the present time does not fire until the counters next reach it
// - after a clear an enabled alarm keeps comparing and fires again
`ifndef RTC_ALARM_CONSTS_SVH
`define RTC_ALARM_CONSTS_SVH

// register indexes; byte address is four times the index
`define IDX_WK_MIN 4'h8
`define IDX_WK_HOUR 4'h9
`define IDX_WK_MASK 4'hA
`define IDX_MO_MIN 4'hB
`define IDX_MO_HOUR 4'hC
`define IDX_MO_DAY 4'hB
`define IDX_MO_MONTH 4'hC
`define IDX_CTRL 4'hE
`define IDX_STAT 4'hF

// control fields
`define CTRL_WK_EN 7
`define CTRL_MO_EN 6
// status fields
`define STAT_BANK 7
`define STAT_WK_FLAG 1
`define STAT_MO_FLAG 0
// compare register fields
`define CMP_ENABLE 7
`define MASK_MIN 8'h7F
`define MASK_HOUR 8'h3F
`define MASK_DAY 8'h3F
`define MASK_MONTH 8'h1F
`define MASK_WEEK 8'h7F

`define REG_RESET 8'h00

// flag delay after a match
`define FLAG_DELAY_NS 61000
`define CLK_PERIOD_NS 25
`define FLAG_DELAY_CYC (`FLAG_DELAY_NS / `CLK_PERIOD_NS)

`endif

// >>> hw/rtc_alarm_match_unit.sv
// alarm match unit with AHB-Lite register slave
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ps
`include "rtc_alarm_consts.svh"

module rtc_alarm_match_unit
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire rtc_alarm_pkg::time_s cur_time,
  input wire logic minute_tick,
  input wire logic power_on_flag,
  output logic int_n_o,
  output logic int_n_oe
);
  import rtc_alarm_pkg::*;

  localparam logic [11:0] DELAY_LAST = 12'(`FLAG_DELAY_CYC - 1);

  logic [7:0] wk_min;
  logic [7:0] wk_hour;
  logic [7:0] wk_mask;
  logic [7:0] mo_min;
  logic [7:0] mo_hour;
  logic [7:0] mo_day;
  logic [7:0] mo_month;
  logic bank;
  logic [1:0] alarm_en;
  logic [1:0] flag;
  logic [1:0] busy;
  logic [11:0] cnt [2];
  logic [1:0] hit;
  logic [1:0] done;
  logic [1:0] clr;
  logic por_prev;
  logic por_rise;
  bus_state_e bus_state;
  logic wr_pend;
  logic [3:0] wr_idx;
  logic wr_ok;
  logic [3:0] rd_idx;
  logic rd_ok;
  logic addr_take;
  logic addr_ok;
  logic [7:0] wd;
  logic [7:0] next_rdata;

  function automatic logic masked_eq(input logic [7:0] a, input logic [7:0] b,
                                     input logic [7:0] m);
    masked_eq = ((a ^ b) & m) == 8'h00;
  endfunction

  // power-on flag edge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      por_prev <= 1'b0;
    else
      por_prev <= power_on_flag;
  end
  assign por_rise = power_on_flag & ~por_prev;

  // compare logic
  always_comb
  begin
    // 12-hour PM 12 is BCD 32, compared raw like any other hour code
    hit[slot_week] = masked_eq(wk_min, cur_time.minute, `MASK_MIN)
      & masked_eq(wk_hour, cur_time.hour, `MASK_HOUR)
      & wk_mask[cur_time.weekday] & (cur_time.weekday != 3'h7)
      & ((wk_mask & `MASK_WEEK) != 8'h00);
    hit[slot_date] = masked_eq(mo_min, cur_time.minute, `MASK_MIN)
      & masked_eq(mo_hour, cur_time.hour, `MASK_HOUR)
      & (!mo_day[`CMP_ENABLE] | masked_eq(mo_day, cur_time.day, `MASK_DAY))
      & (!mo_month[`CMP_ENABLE]
         | masked_eq(mo_month, cur_time.month, `MASK_MONTH));
  end

  // delay from match to flag
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      busy <= 2'b00;
      cnt[0] <= 12'h000;
      cnt[1] <= 12'h000;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (!alarm_en[i])
        begin
          busy[i] <= 1'b0;
          cnt[i] <= 12'h000;
        end
        else if (busy[i])
        begin
          busy[i] <= (cnt[i] != DELAY_LAST);
          cnt[i] <= cnt[i] + 12'h001;
        end
        else if (minute_tick && hit[i])
        begin
          busy[i] <= 1'b1;
          cnt[i] <= 12'h000;
        end
      end
    end
  end

  always_comb
  begin
    for (int i = 0; i < 2; i++)
      done[i] = busy[i] & (cnt[i] == DELAY_LAST);
  end

  // bus address phase
  assign addr_take = hsel & hready & htrans[1];
  assign addr_ok = (haddr[31:6] == 26'h0) & (haddr[1:0] == 2'b00);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_idx <= 4'h0;
      wr_ok <= 1'b0;
      rd_idx <= 4'h0;
      rd_ok <= 1'b0;
    end
    else
    begin
      wr_pend <= addr_take & hwrite;
      if (addr_take)
      begin
        wr_idx <= haddr[5:2];
        wr_ok <= addr_ok;
        rd_idx <= haddr[5:2];
        rd_ok <= addr_ok;
      end
    end
  end

  // reads take one wait state so a write just before is seen
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus_state <= bus_idle;
      hreadyout <= 1'b1;
      hrdata <= 32'h00000000;
    end
    else
    begin
      case (bus_state)
        bus_idle:
        begin
          if (addr_take && !hwrite)
          begin
            bus_state <= bus_read;
            hreadyout <= 1'b0;
          end
        end
        bus_read:
        begin
          bus_state <= bus_idle;
          hreadyout <= 1'b1;
          hrdata <= {24'h000000, next_rdata};
        end
        default:
        begin
          bus_state <= bus_idle;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hresp <= 1'b0;
    else
      hresp <= 1'b0;
  end

  always_comb
  begin
    next_rdata = 8'h00;
    if (rd_ok)
    begin
      case (rd_idx)
        `IDX_WK_MIN: next_rdata = wk_min;
        `IDX_WK_HOUR: next_rdata = wk_hour;
        `IDX_WK_MASK: next_rdata = wk_mask;
        `IDX_MO_MIN: next_rdata = bank ? mo_day : mo_min;
        `IDX_MO_HOUR: next_rdata = bank ? mo_month : mo_hour;
        `IDX_CTRL:
        begin
          next_rdata[`CTRL_WK_EN] = alarm_en[slot_week];
          next_rdata[`CTRL_MO_EN] = alarm_en[slot_date];
        end
        `IDX_STAT:
        begin
          next_rdata[`STAT_BANK] = bank;
          next_rdata[`STAT_WK_FLAG] = flag[slot_week] & alarm_en[slot_week];
          next_rdata[`STAT_MO_FLAG] = flag[slot_date] & alarm_en[slot_date];
        end
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // register writes
  assign wd = hwdata[7:0];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wk_min <= `REG_RESET;
      wk_hour <= `REG_RESET;
      wk_mask <= `REG_RESET;
      mo_min <= `REG_RESET;
      mo_hour <= `REG_RESET;
      mo_day <= `REG_RESET;
      mo_month <= `REG_RESET;
    end
    else if (por_rise)
    begin
      wk_min <= `REG_RESET;
      wk_hour <= `REG_RESET;
      wk_mask <= `REG_RESET;
      mo_min <= `REG_RESET;
      mo_hour <= `REG_RESET;
      mo_day <= `REG_RESET;
      mo_month <= `REG_RESET;
    end
    else if (wr_pend && wr_ok)
    begin
      // all eight bits stored whatever the enables
      case (wr_idx)
        `IDX_WK_MIN: wk_min <= wd;
        `IDX_WK_HOUR: wk_hour <= wd;
        `IDX_WK_MASK: wk_mask <= wd;
        `IDX_MO_MIN:
        begin
          if (bank)
            mo_day <= wd;
          else
            mo_min <= wd;
        end
        `IDX_MO_HOUR:
        begin
          if (bank)
            mo_month <= wd;
          else
            mo_hour <= wd;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      alarm_en <= 2'b00;
      bank <= 1'b0;
    end
    else if (por_rise)
    begin
      alarm_en <= 2'b00;
      bank <= 1'b0;
    end
    else if (wr_pend && wr_ok)
    begin
      if (wr_idx == `IDX_CTRL)
      begin
        alarm_en[slot_week] <= wd[`CTRL_WK_EN];
        alarm_en[slot_date] <= wd[`CTRL_MO_EN];
      end
      if (wr_idx == `IDX_STAT)
        bank <= wd[`STAT_BANK];
    end
  end

  // status flags: a set in the same cycle as a clear wins
  always_comb
  begin
    clr = 2'b00;
    if (wr_pend && wr_ok && wr_idx == `IDX_STAT)
    begin
      clr[slot_week] = ~wd[`STAT_WK_FLAG];
      clr[slot_date] = ~wd[`STAT_MO_FLAG];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      flag <= 2'b00;
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (!alarm_en[i])
          flag[i] <= 1'b0;
        else if (done[i])
          flag[i] <= 1'b1;
        else if (clr[i])
          flag[i] <= 1'b0;
      end
    end
  end

  // open-drain interrupt pin, low while a flag stands
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      int_n_o <= 1'b0;
      int_n_oe <= 1'b0;
    end
    else
    begin
      int_n_o <= 1'b0;
      int_n_oe <= |next_flag_or(alarm_en, done, clr, flag);
    end
  end

  function automatic logic [1:0] next_flag_or(input logic [1:0] en, input logic [1:0] dn,
                                               input logic [1:0] cl, input logic [1:0] fl);
    next_flag_or = en & (dn | (fl & ~cl));
  endfunction

  a_flag_delay: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(flag[slot_week]) |-> $past(busy[slot_week]) && $past(cnt[slot_week]) == DELAY_LAST)
    else $error("weekly flag set without full delay");

  a_flag_write_one: assert property (@(posedge hclk) disable iff (!hresetn)
    !flag[slot_date] && !done[slot_date] |=> !flag[slot_date])
    else $error("date flag set without alarm");

  a_flag_clear_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    clr[slot_week] && !done[slot_week] |=> !flag[slot_week])
    else $error("weekly flag not cleared by zero write");

  a_disabled_flag_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    !alarm_en[slot_date] |=> !flag[slot_date])
    else $error("date flag standing while disabled");

  a_empty_mask: assert property (@(posedge hclk) disable iff (!hresetn)
    (wk_mask & `MASK_WEEK) == 8'h00 |-> !hit[slot_week])
    else $error("weekly match with empty day mask");

  a_day_ignored: assert property (@(posedge hclk) disable iff (!hresetn)
    !mo_day[`CMP_ENABLE] && !mo_month[`CMP_ENABLE] && masked_eq(mo_min, cur_time.minute,
    `MASK_MIN) && masked_eq(mo_hour, cur_time.hour, `MASK_HOUR) |-> hit[slot_date])
    else $error("daily alarm blocked by disabled day or month");

  a_por_clears: assert property (@(posedge hclk) disable iff (!hresetn)
    por_rise |=> wk_min == 8'h00 && wk_mask == 8'h00 && mo_day == 8'h00 && mo_month == 8'h00)
    else $error("compare registers not zeroed on power-on");

  a_int_pin: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 int_n_oe == (|flag))
    else $error("interrupt pin disagrees with flags");

  a_tick_start: assert property (@(posedge hclk) disable iff (!hresetn)
    !busy[slot_date] && !minute_tick |=> !busy[slot_date])
    else $error("date compare started without minute update");

  a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    bus_state == bus_idle && addr_take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read answer timing wrong");

  c_week_fire: cover property (@(posedge hclk) disable iff (!hresetn) $rose(flag[slot_week]));
  c_date_fire: cover property (@(posedge hclk) disable iff (!hresetn) $rose(flag[slot_date]));
  c_set_beats_clear: cover property (@(posedge hclk) disable iff (!hresetn)
    done[slot_date] && clr[slot_date]);
  c_yearly: cover property (@(posedge hclk) disable iff (!hresetn)
    hit[slot_date] && mo_day[`CMP_ENABLE] && mo_month[`CMP_ENABLE]);

endmodule

// >>> hw/rtc_alarm_pkg.sv
// types shared by the alarm unit
package rtc_alarm_pkg;
  typedef struct packed
  {
    logic [7:0] minute;
    logic [7:0] hour;
    logic [2:0] weekday;
    logic [7:0] day;
    logic [7:0] month;
  } time_s;

  typedef enum logic [0:0] {bus_idle, bus_read} bus_state_e;

  // alarm slots
  typedef enum logic [0:0] {slot_date, slot_week} slot_e;
endpackage
